// ===== core/sdc_top.sv
// control and result path of the multiplexed sigma-delta converter
// Contract
// - results are 16 bits from the selected differential input pair
// - two independent ten-way selectors feed the positive and negative inputs
// - conversion rate is programmable, fastest setting 512 samples per second
// - single conversion waits four output periods; 40 sps gives 10 sps
// - unipolar spans zero to reference, bipolar minus to plus reference
// - range fault flag marks a result beyond full scale, below zero when unipolar or below minus full scale when bipolar
// - zero and full scale calibration store corrections for later results
// - host reads and writes the gain and zero calibration values
// - zero correction accepts a deliberate positive offset skew
// - conversion done routes to the interrupt pin or any user pin
// - two-bit field selects gain 1, 2, 4 or 8 on the filtered word
// - filter reduces the modulator bit stream to results
// - comparator trip asserts interrupt within 30 us and keeps it
// - comparator threshold selects 0, 50, 100, 150 or 200 mV
// - reference buffer is off after reset until host enables it
// - four-bit select fields; swap bit exchanges mux outputs to converter
// - decimator is fourth-order sinc, settled after four output periods
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_top import sdc_pkg::*; #(
	parameter int MOD_DIV = `SDC_MOD_DIV
) (
	input  wire logic        clk_sys_i,            // 40 MHz system clock
	input  wire logic        sys_rst_i,            // synchronous reset
	input  wire logic        mod_bit_i,            // modulator bit stream
	input  wire logic        cmp_above_i,          // comparator trip level
	input  wire logic [3:0]  pos_input_select_i,   // positive selector
	input  wire logic [3:0]  neg_input_select_i,   // negative selector
	input  wire logic        input_swap_i,         // swap converter inputs
	input  wire logic [2:0]  rate_sel_i,           // output rate code
	input  wire logic        pga_scale_bit_high_i, // gain field high bit
	input  wire logic        pga_scale_bit_low_i,  // gain field low bit
	input  wire logic        bipolar_i,            // bipolar result mode
	input  wire logic        start_i,              // start pulse
	input  wire logic [1:0]  op_i,                 // conv, zero or full cal
	input  wire logic        continuous_i,         // keep converting
	input  wire logic        cal_wr_zero_i,        // load zero correction
	input  wire logic        cal_wr_gain_i,        // load gain correction
	input  wire logic [23:0] cal_wdata_i,          // correction value
	input  wire logic [2:0]  done_route_i,         // done destination
	input  wire logic        done_clr_i,           // clear done flag
	input  wire logic        detect_clr_i,         // clear signal detect
	input  wire logic [2:0]  thresh_sel_i,         // comparator threshold
	input  wire logic        ref_buf_en_i,         // reference buffer on
	input  wire logic        result_ready_i,       // reader takes result
	output logic             result_valid_o,       // result held
	output logic      [15:0] result_data_o,        // conversion result
	output logic             range_fault_flag_o,   // result was clipped
	output logic      [3:0]  adc_mux_p_o,          // converter + select
	output logic      [3:0]  adc_mux_n_o,          // converter - select
	output logic      [3:0]  cmp_mux_p_o,          // comparator + select
	output logic      [3:0]  cmp_mux_n_o,          // comparator - select
	output logic      [2:0]  cmp_thresh_o,         // threshold code
	output logic             ref_buf_en_o,         // reference buffer on
	output logic      [23:0] zero_cal_o,           // zero correction
	output logic      [23:0] gain_cal_o,           // gain correction
	output logic             busy_o,               // operation running
	output logic             done_flag_o,          // sticky done
	output logic             int_o,                // interrupt, high
	output logic      [3:0]  user_io_pins_o        // user pins, done
);
	if (MOD_DIV < 2 || MOD_DIV > 4095) begin : g_chk
		$error("sdc_top: MOD_DIV out of range");
	end

	localparam int DET_CYC = `SDC_DETECT_CYC;
	localparam logic [76:0] DEC_TAB = `SDC_DEC_TABLE;
	localparam logic [34:0] SH_TAB  = `SDC_SHIFT_TABLE;
	typedef struct packed {
		logic [2:0]  sync_mod;
		logic [2:0]  sync_cmp;
		logic        mod_lvl;
		logic        cmp_lvl;
		logic [11:0] div;
		logic        tick;
		logic        restart;
		sdc_state_t  st;
		sdc_op_t     op;
		logic        cont;
		logic [1:0]  settle;
		logic [23:0] zero;
		logic [23:0] gain;
		logic        pend;
		logic [16:0] pend_data;
		logic        done;
		logic        detect;
		logic [5:0]  dcnt;
		logic [27:0] rem;
		logic [23:0] quo;
		logic [27:0] den;
		logic        sat;
		logic [3:0]  mp;
		logic [3:0]  mn;
		logic [3:0]  cp;
		logic [3:0]  cn;
		logic [2:0]  thr;
		logic        ref_en;
		logic [10:0] lat;
	} sdc_top_st_t;

	sdc_top_st_t        s_q, s_d;
	logic [47:0]        sinc_data;
	logic               sinc_valid;
	logic               buf_ready;
	logic [16:0]        buf_data;
	logic [2:0]         rate_idx;
	logic [10:0]        dec_len;
	logic [4:0]         norm_sh;
	logic signed [47:0] norm_full;
	logic signed [27:0] vg;
	logic signed [27:0] c1;
	logic signed [52:0] prod;
	logic signed [30:0] c2;
	logic signed [30:0] uni;
	logic signed [30:0] bip;
	logic [16:0]        res;
	logic [28:0]        rem2;
	logic               q_bit;
	logic [3:0]         p_sel;
	logic [3:0]         n_sel;

	// codes above the fastest rate fall back to it
	assign rate_idx  = (rate_sel_i > `SDC_MAX_RATE) ? `SDC_MAX_RATE
		: rate_sel_i;
	assign dec_len   = DEC_TAB[rate_idx*11 +: 11];
	assign norm_sh   = SH_TAB[rate_idx*5 +: 5];
	assign norm_full = $signed(sinc_data) >>> norm_sh;
	// gain acts on the filtered word, so no analog stage changes
	assign vg = norm_full[27:0] <<< {pga_scale_bit_high_i,
		pga_scale_bit_low_i};
	assign c1   = vg - {{4{s_q.zero[23]}}, s_q.zero};
	assign prod = c1 * $signed({1'b0, s_q.gain});
	assign c2   = prod[52:`SDC_GAIN_FRAC];
	assign uni  = c2 >>> 4;
	assign bip  = c2 >>> 5;

	always_comb begin
		res = '0;
		if (!bipolar_i) begin
			if (uni < 0)
				res = {1'b1, 16'h0000};
			else if (uni > $signed(`SDC_UNI_MAX))
				res = {1'b1, 16'hffff};
			else
				res = {1'b0, uni[15:0]};
		end else begin
			if (bip < $signed(`SDC_BIP_MIN))
				res = {1'b1, 16'h0000};
			else if (bip > $signed(`SDC_BIP_MAX))
				res = {1'b1, 16'hffff};
			else
				res = {1'b0, bip[15:0] + `SDC_BIP_MID};
		end
	end

	assign rem2  = {s_q.rem, s_q.dcnt == `SDC_DIV_BITS};
	assign q_bit = rem2 >= {1'b0, s_q.den};
	assign p_sel = input_swap_i ? neg_input_select_i : pos_input_select_i;
	assign n_sel = input_swap_i ? pos_input_select_i : neg_input_select_i;

	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		s_d.tick = 1'b0;
		// only stage two and three are compared, stage one feeds stage two
		s_d.sync_mod = {s_q.sync_mod[1:0], mod_bit_i};
		s_d.sync_cmp = {s_q.sync_cmp[1:0], cmp_above_i};
		if (s_q.sync_mod[1] == s_q.sync_mod[2])
			s_d.mod_lvl = s_q.sync_mod[2];
		if (s_q.sync_cmp[1] == s_q.sync_cmp[2])
			s_d.cmp_lvl = s_q.sync_cmp[2];
		if (s_q.div >= 12'(MOD_DIV - 1)) begin
			s_d.div = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 12'h1;
		end
		// illegal selector codes park on input zero
		s_d.mp = (p_sel < `SDC_NUM_INPUTS) ? p_sel : 4'h0;
		s_d.mn = (n_sel < `SDC_NUM_INPUTS) ? n_sel : 4'h0;
		s_d.cp = (pos_input_select_i < `SDC_NUM_INPUTS)
			? pos_input_select_i : 4'h0;
		s_d.cn = (neg_input_select_i < `SDC_NUM_INPUTS)
			? neg_input_select_i : 4'h0;
		s_d.thr = (thresh_sel_i > `SDC_MAX_THRESH) ? `SDC_MAX_THRESH
			: thresh_sel_i;
		s_d.ref_en = ref_buf_en_i;
		if (cal_wr_zero_i)
			s_d.zero = cal_wdata_i;
		if (cal_wr_gain_i)
			s_d.gain = cal_wdata_i;
		s_d.detect = s_q.cmp_lvl || (s_q.detect && !detect_clr_i);
		s_d.done = s_q.done && !done_clr_i;
		if (s_q.pend && buf_ready) begin
			s_d.pend = 1'b0;
			s_d.done = 1'b1;
		end
		case (s_q.st)
		ST_IDLE: begin
		end
		ST_RUN: begin
			if (sinc_valid && !s_q.restart) begin
				if (s_q.settle != 2'(`SDC_SETTLE_N - 1)) begin
					s_d.settle = s_q.settle + 2'h1;
				end else if (s_q.op == OP_CONV) begin
					// a stalled reader drops new words, never the held one
					if (!s_d.pend) begin
						s_d.pend = 1'b1;
						s_d.pend_data = res;
					end
					if (!s_q.cont)
						s_d.st = ST_IDLE;
				end else if (s_q.op == OP_ZERO) begin
					s_d.zero = vg[23:0];
					s_d.done = 1'b1;
					s_d.st = ST_IDLE;
				end else begin
					s_d.den = c1;
					s_d.sat = c1 <= $signed(`SDC_DIV_MIN_DEN);
					s_d.rem = '0;
					s_d.quo = '0;
					s_d.dcnt = `SDC_DIV_BITS;
					s_d.st = ST_DIV;
				end
			end
		end
		ST_DIV: begin
			s_d.rem = q_bit ? 28'(rem2 - {1'b0, s_q.den}) : rem2[27:0];
			s_d.quo = {s_q.quo[22:0], q_bit};
			s_d.dcnt = s_q.dcnt - 6'h1;
			if (s_q.dcnt == 6'h0) begin
				s_d.gain = s_q.sat ? 24'hffffff : s_d.quo;
				s_d.done = 1'b1;
				s_d.st = ST_IDLE;
			end
		end
		default: s_d.st = ST_IDLE;
		endcase
		if (start_i && op_i != 2'h3) begin
			s_d.st = ST_RUN;
			s_d.op = sdc_op_t'(op_i);
			s_d.cont = continuous_i && op_i == 2'h0;
			s_d.settle = '0;
			s_d.restart = 1'b1;
		end
		s_d.lat = (cmp_above_i && !int_o) ? s_q.lat + 11'h1 : '0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.zero <= `SDC_ZERO_RST;
			s_q.gain <= `SDC_GAIN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	sdc_sinc4 #(
		.ACC_W (48)
	) u_sinc (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.tick_i    (s_q.tick),
		.bit_i     (s_q.mod_lvl),
		.restart_i (s_q.restart),
		.dec_len_i (dec_len),
		.data_o    (sinc_data),
		.valid_o   (sinc_valid)
	);

	sdc_skid #(
		.W (17)
	) u_buf (
		.clk_sys_i   (clk_sys_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (s_q.pend),
		.in_ready_o  (buf_ready),
		.in_data_i   (s_q.pend_data),
		.out_valid_o (result_valid_o),
		.out_ready_i (result_ready_i),
		.out_data_o  (buf_data)
	);

	assign result_data_o      = buf_data[15:0];
	assign range_fault_flag_o = buf_data[16];
	assign adc_mux_p_o        = s_q.mp;
	assign adc_mux_n_o        = s_q.mn;
	assign cmp_mux_p_o        = s_q.cp;
	assign cmp_mux_n_o        = s_q.cn;
	assign cmp_thresh_o       = s_q.thr;
	assign ref_buf_en_o       = s_q.ref_en;
	assign zero_cal_o         = s_q.zero;
	assign gain_cal_o         = s_q.gain;
	assign busy_o             = s_q.st != ST_IDLE;
	assign done_flag_o        = s_q.done;
	assign int_o = s_q.detect
		|| (s_q.done && done_route_i == 3'h0);
	for (genvar i = 0; i < 4; i++) begin : g_uio
		assign user_io_pins_o[i] = s_q.done
			&& done_route_i == 3'(i + 1);
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	a_mux_swap: assert property (input_swap_i
		&& neg_input_select_i < 4'ha |=> adc_mux_p_o == $past(
		neg_input_select_i)) else $error("swap not applied");
	a_mux_range: assert property (adc_mux_p_o < 4'ha && adc_mux_n_o < 4'ha
		&& cmp_mux_p_o < 4'ha) else $error("selector out of range");
	a_ref_reset: assert property (disable iff (1'b0) sys_rst_i
		|=> !ref_buf_en_o) else $error("reference on after reset");
	a_thresh_range: assert property (cmp_thresh_o <= 3'h4)
		else $error("threshold code out of range");
	a_detect_hold: assert property (s_q.detect && !detect_clr_i |=> int_o)
		else $error("detect interrupt dropped");
	a_detect_time: assert property (s_q.lat < 11'(DET_CYC))
		else $error("detect interrupt too late");
	a_done_route: assert property (done_flag_o && done_route_i == 3'h2
		|-> user_io_pins_o == 4'h2) else $error("done routing wrong");
	a_settle_wait: assert property ($rose(s_q.pend) |-> $past(s_q.settle)
		== 2'h3) else $error("result taken before settling");
	a_fault_clip: assert property (s_q.pend && s_q.pend_data[16]
		|-> s_q.pend_data[15:0] == 16'h0 || s_q.pend_data[15:0] == 16'hffff)
		else $error("fault without clipping");
	a_done_set: assert property (s_q.pend && buf_ready |=> done_flag_o)
		else $error("done not set on result");
	a_gain_write: assert property (cal_wr_gain_i && !busy_o |=> gain_cal_o
		== $past(cal_wdata_i)) else $error("gain write lost");

	c_conv_result: cover property ($rose(s_q.pend));
	c_full_cal: cover property (s_q.st == ST_DIV ##1 s_q.st == ST_IDLE);
	c_zero_cal: cover property (s_q.op == OP_ZERO && $fell(busy_o));
	c_detect: cover property ($rose(int_o) && s_q.detect);
endmodule

// ===== core/sdc_defines.svh
// timing counts, tables and reset values of the converter control block
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

`define SDC_CLK_HZ      40000000
`define SDC_CLK_NS      25
`define SDC_MOD_HZ      16384
`define SDC_MOD_DIV     (`SDC_CLK_HZ / `SDC_MOD_HZ)
`define SDC_DETECT_NS   30000
`define SDC_DETECT_CYC  (`SDC_DETECT_NS / `SDC_CLK_NS)
`define SDC_SETTLE_N    4
`define SDC_NUM_INPUTS  10
`define SDC_MAX_THRESH  3'h4
`define SDC_MAX_RATE    3'h6
`define SDC_DEC_TABLE   {11'd32, 11'd51, 11'd102, 11'd205, 11'd410, \
	11'd819, 11'd1638}
`define SDC_SHIFT_TABLE {5'd0, 5'd2, 5'd6, 5'd10, 5'd14, 5'd18, 5'd22}
`define SDC_ZERO_RST    24'h000000
`define SDC_GAIN_RST    24'h400000
`define SDC_GAIN_FRAC   22
`define SDC_DIV_BITS    6'h2a
`define SDC_DIV_MIN_DEN 28'h0040000
`define SDC_UNI_MAX     31'h0000ffff
`define SDC_BIP_MAX     31'h00007fff
`define SDC_BIP_MIN     31'h7fff8000
`define SDC_BIP_MID     16'h8000

`endif

// ===== core/sdc_pkg.sv
// shared types of the converter control block
package sdc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DIV} sdc_state_t;
	typedef enum logic [1:0] {OP_CONV, OP_ZERO, OP_FULL} sdc_op_t;
endpackage

// ===== core/sdc_sinc4.sv
// fourth-order sinc decimator for the single-bit modulator stream
`timescale 1ns/1ps
module sdc_sinc4 import sdc_pkg::*; #(
	parameter int ACC_W = 48
) (
	input  wire logic             clk_sys_i,  // system clock
	input  wire logic             sys_rst_i,  // synchronous reset
	input  wire logic             tick_i,     // modulator sample strobe
	input  wire logic             bit_i,      // modulator output bit
	input  wire logic             restart_i,  // clear filter history
	input  wire logic [10:0]      dec_len_i,  // decimation length
	output logic      [ACC_W-1:0] data_o,     // filtered word
	output logic                  valid_o     // one-cycle word strobe
);
	if (ACC_W < 45) begin : g_chk
		$error("sdc_sinc4: ACC_W too small for 1638^4");
	end

	typedef struct packed {
		logic [3:0][ACC_W-1:0] integ;
		logic [3:0][ACC_W-1:0] dly;
		logic [10:0]           cnt;
		logic [ACC_W-1:0]      data;
		logic                  valid;
	} sdc_sinc_st_t;

	sdc_sinc_st_t s_q, s_d;

	always_comb begin
		logic [ACC_W-1:0] y;
		logic [ACC_W-1:0] t;
		y = '0;
		t = '0;
		s_d = s_q;
		s_d.valid = 1'b0;
		if (restart_i) begin
			s_d = '0;
		end else if (tick_i) begin
			// +1 for a one, -1 for a zero: duty cycle becomes the mean
			s_d.integ[0] = s_q.integ[0] + (bit_i ? ACC_W'(1) : '1);
			// chained within the tick, so the fourth word sees a full window
			for (int i = 1; i < 4; i++) begin
				s_d.integ[i] = s_q.integ[i] + s_d.integ[i-1];
			end
			if (s_q.cnt >= dec_len_i - 11'h1) begin
				s_d.cnt = '0;
				y = s_d.integ[3];
				for (int i = 0; i < 4; i++) begin
					t = y;
					y = y - s_q.dly[i];
					s_d.dly[i] = t;
				end
				s_d.data = y;
				s_d.valid = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 11'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign data_o  = s_q.data;
	assign valid_o = s_q.valid;
endmodule

// ===== core/sdc_skid.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module sdc_skid import sdc_pkg::*; #(
	parameter int W = 17
) (
	input  wire logic         clk_sys_i,  // system clock
	input  wire logic         sys_rst_i,  // synchronous reset
	input  wire logic         in_valid_i, // word offered
	output logic              in_ready_o, // room for a word
	input  wire logic [W-1:0] in_data_i,  // word in
	output logic              out_valid_o,// word held
	input  wire logic         out_ready_i,// reader takes the word
	output logic      [W-1:0] out_data_o  // word out
);
	if (W < 1) begin : g_chk
		$error("sdc_skid: W must be positive");
	end

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
		logic              wp;
		logic              rp;
	} sdc_skid_st_t;

	sdc_skid_st_t s_q, s_d;
	logic         push;
	logic         pop;

	assign in_ready_o  = s_q.cnt != 2'h2;
	assign out_valid_o = s_q.cnt != 2'h0;
	assign out_data_o  = s_q.mem[s_q.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data_i;
			s_d.wp = ~s_q.wp;
		end
		if (pop)
			s_d.rp = ~s_q.rp;
		s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	a_skid_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
		else $error("held result changed before it was read");
endmodule

// ===== tb/sdc_far_model.sv
// far side model: modulator stream, comparator and result reader
`timescale 1ns/1ps
module sdc_far_model #(
	parameter int DIV = 4
) (
	input  wire logic       clk_i,       // system clock
	input  wire logic [1:0] pat_i,       // 0 zeros, 1 ones, 2 alternate
	input  wire logic [7:0] sig_mv_i,    // differential level in mV
	input  wire logic [2:0] thresh_i,    // threshold code from block
	input  wire logic       stall_i,     // reader holds off
	input  wire logic       fast_i,      // reader takes every word at once
	output logic            mod_bit_o,   // modulator stream
	output logic            cmp_above_o, // comparator output
	output logic            ready_o      // reader takes result
);
	int         div_q = 0;
	logic       alt_q = 1'b0;
	logic [1:0] rdy_q = 2'h0;
	// bit held a whole modulator period so every tick sees one value
	always @(posedge clk_i) begin
		div_q <= (div_q == DIV - 1) ? 0 : div_q + 1;
		if (div_q == 0)
			alt_q <= ~alt_q;
		rdy_q <= rdy_q + 2'h1;
	end
	assign mod_bit_o = (pat_i == 2'h1) | ((pat_i == 2'h2) & alt_q);
	// analog side applies the 50 mV steps of the threshold code
	assign cmp_above_o = 9'(sig_mv_i) > 9'(thresh_i) * 9'd50;
	// slow reader takes a word only one cycle in four
	assign ready_o = ~stall_i & (fast_i | (rdy_q == 2'h3));
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sdc_defines.svh"
module tb_top;
	localparam int MDIV  = 4;
	localparam int DEC40 = 410;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        mod_bit, cmp_above, rdy, start, cont, swap, bip;
	logic        ghi, glo, wz, wg, dclr, tclr, refen, stall, fast;
	logic [1:0]  op, pat;
	logic [2:0]  rate, route, thr, tho;
	logic [3:0]  psel, nsel, amp, amn, cmpp, cmpn, upins;
	logic [23:0] wdata, zc, gc;
	logic [7:0]  sig;
	logic        valid, fault, busy, done, irq, refo;
	logic [15:0] rdata;
	logic [16:0] exp_q[$];
	logic [16:0] last_exp = 17'h0;
	int          num_errors = 0;
	int          check_count = 0;
	int          seed = 32'h39a4;
	int          n;

	always #12.5 clk_sys_i = ~clk_sys_i;

	sdc_top #(.MOD_DIV(MDIV)) uut (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.mod_bit_i(mod_bit), .cmp_above_i(cmp_above),
		.pos_input_select_i(psel), .neg_input_select_i(nsel),
		.input_swap_i(swap), .rate_sel_i(rate),
		.pga_scale_bit_high_i(ghi), .pga_scale_bit_low_i(glo),
		.bipolar_i(bip), .start_i(start), .op_i(op),
		.continuous_i(cont), .cal_wr_zero_i(wz), .cal_wr_gain_i(wg),
		.cal_wdata_i(wdata), .done_route_i(route), .done_clr_i(dclr),
		.detect_clr_i(tclr), .thresh_sel_i(thr), .ref_buf_en_i(refen),
		.result_ready_i(rdy), .result_valid_o(valid),
		.result_data_o(rdata), .range_fault_flag_o(fault),
		.adc_mux_p_o(amp), .adc_mux_n_o(amn), .cmp_mux_p_o(cmpp),
		.cmp_mux_n_o(cmpn), .cmp_thresh_o(tho), .ref_buf_en_o(refo),
		.zero_cal_o(zc), .gain_cal_o(gc), .busy_o(busy),
		.done_flag_o(done), .int_o(irq), .user_io_pins_o(upins)
	);

	sdc_far_model #(.DIV(MDIV)) far (
		.clk_i(clk_sys_i), .pat_i(pat), .sig_mv_i(sig), .thresh_i(tho),
		.stall_i(stall), .fast_i(fast), .mod_bit_o(mod_bit),
		.cmp_above_o(cmp_above), .ready_o(rdy)
	);

	task automatic check_val(input string what, input logic [23:0] seen,
		input logic [23:0] want);
		check_count++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// results taken at the edge where valid and ready meet
	always @(posedge clk_sys_i)
		if (!sys_rst_i && valid === 1'b1 && rdy === 1'b1) begin
			if (exp_q.size() > 0)
				last_exp = exp_q.pop_front();
			check_val("result", 24'({fault, rdata}), 24'(last_exp));
		end

	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys_i);
	endtask

	task automatic run_op(input logic [1:0] o, input logic c);
		op = o;
		cont = c;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
	endtask

	task automatic wait_busy;
		n = 0;
		while (busy !== 1'b0 && n < 8000) begin
			cyc(1);
			n++;
		end
		check_val("busy_end", 24'(busy), 24'h0);
	endtask

	task automatic wait_q;
		n = 0;
		while (exp_q.size() > 0 && n < 8000) begin
			cyc(1);
			n++;
		end
		check_val("result_count", 24'(exp_q.size()), 24'h0);
	endtask

	task automatic wait_valid;
		n = 0;
		while (valid !== 1'b1 && n < 8000) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic conv(input logic [16:0] e);
		exp_q.push_back(e);
		run_op(2'h0, 1'b0);
		wait_q;
	endtask

	// host recalibrates after every change of rate
	task automatic zcal;
		run_op(2'h1, 1'b0);
		wait_busy;
		check_val("cal_done", 24'(done), 24'h1);
		dclr = 1'b1;
		cyc(1);
		dclr = 1'b0;
	endtask

	function automatic logic [3:0] lim(input logic [3:0] s);
		return (s < 4'ha) ? s : 4'h0;
	endfunction

	initial begin
		{start, cont, swap, bip, ghi, glo, wz, wg} = 8'h00;
		{dclr, tclr, refen, stall, fast} = 5'h01;
		{op, pat, rate, route, thr} = {2'h0, 2'h2, 3'h6, 3'h7, 3'h0};
		{psel, nsel, wdata, sig} = 40'h0;
		cyc(5);
		sys_rst_i = 1'b0;
		check_val("ref_rst", 24'(refo), 24'h0);
		check_val("gain_rst", gc, `SDC_GAIN_RST);
		check_val("zero_rst", zc, `SDC_ZERO_RST);
		refen = 1'b1;
		cyc(1);
		check_val("ref_on", 24'(refo), 24'h1);
		for (int i = 0; i < 16; i++) begin
			psel = 4'($random(seed));
			nsel = 4'($random(seed));
			swap = 1'($random(seed));
			cyc(2);
			check_val("adc_p", 24'(amp), 24'(swap ? lim(nsel) : lim(psel)));
			check_val("adc_n", 24'(amn), 24'(swap ? lim(psel) : lim(nsel)));
			check_val("cmp_p", 24'({cmpp, cmpn}), 24'({lim(psel), lim(nsel)}));
		end
		for (int t = 0; t < 8; t++) begin
			thr = 3'(t);
			cyc(2);
			check_val("thresh", 24'(tho), 24'((t > 4) ? 4 : t));
		end
		wdata = 24'hfffc00;
		wz = 1'b1;
		cyc(1);
		wz = 1'b0;
		check_val("zero_wr", zc, 24'hfffc00);
		wdata = 24'($random(seed));
		wg = 1'b1;
		cyc(1);
		wg = 1'b0;
		check_val("gain_wr", gc, wdata);
		wdata = `SDC_GAIN_RST;
		wg = 1'b1;
		cyc(1);
		wg = 1'b0;
		sig = 8'd120;
		thr = 3'h3;
		cyc(1300);
		check_val("no_trip", 24'(irq), 24'h0);
		thr = 3'h2;
		n = 0;
		while (irq !== 1'b1 && n < 1300) begin
			cyc(1);
			n++;
		end
		check_val("trip_time", 24'(n <= 1200), 24'h1);
		sig = 8'd0;
		cyc(8);
		check_val("trip_held", 24'(irq), 24'h1);
		tclr = 1'b1;
		cyc(1);
		tclr = 1'b0;
		cyc(2);
		check_val("trip_clr", 24'(irq), 24'h0);
		thr = 3'h0;
		rate = 3'h2;
		zcal;
		exp_q.push_back(17'h00000);
		run_op(2'h0, 1'b0);
		wait_valid;
		n = n + 1;
		check_val("settle_time", 24'((n >= 4 * DEC40 * MDIV - MDIV - 8) &&
			(n <= 4 * DEC40 * MDIV + MDIV + 8)), 24'h1);
		wait_q;
		rate = 3'h6;
		zcal;
		conv(17'h00000);
		bip = 1'b1;
		conv(17'h08000);
		bip = 1'b0;
		{ghi, glo} = 2'h3;
		conv(17'h00000);
		{ghi, glo} = 2'h0;
		pat = 2'h1;
		conv(17'h1ffff);
		pat = 2'h0;
		conv(17'h10000);
		// full-scale ones minus a skewed zero shows gains 2, 8 and 1
		pat = 2'h1;
		wdata = 24'h1f0000;
		wz = 1'b1;
		cyc(1);
		wz = 1'b0;
		{ghi, glo} = 2'h1;
		conv(17'h01000);
		{ghi, glo} = 2'h3;
		conv(17'h1ffff);
		{ghi, glo} = 2'h0;
		conv(17'h10000);
		wdata = 24'h0;
		wz = 1'b1;
		cyc(1);
		wz = 1'b0;
		pat = 2'h2;
		for (int r = 0; r < 6; r++) begin
			route = 3'(r);
			dclr = 1'b1;
			cyc(1);
			dclr = 1'b0;
			conv(17'h00000);
			check_val("route_int", 24'(irq), 24'(r == 0));
			check_val("route_pin", 24'(upins),
				24'((r > 0 && r < 5) ? (1 << (r - 1)) : 0));
		end
		route = 3'h7;
		pat = 2'h1;
		{ghi, glo} = 2'h1;
		run_op(2'h2, 1'b0);
		wait_busy;
		check_val("full_cal", gc, 24'h200000);
		{ghi, glo} = 2'h0;
		wdata = `SDC_GAIN_RST;
		wg = 1'b1;
		cyc(1);
		wg = 1'b0;
		pat = 2'h2;
		repeat (3) exp_q.push_back(17'h00000);
		run_op(2'h0, 1'b1);
		wait_valid;
		cyc(1);
		wait_valid;
		check_val("rate_gap", 24'(n + 1), 24'(32 * MDIV));
		wait_q;
		stall = 1'b1;
		cyc(6 * 32 * MDIV);
		check_val("held_valid", 24'(valid), 24'h1);
		run_op(2'h1, 1'b0);
		fast = 1'b0;
		stall = 1'b0;
		wait_busy;
		cyc(64);
		check_val("drained", 24'(valid), 24'h0);
		give_verdict;
	end

	initial begin
		repeat (60000) @(posedge clk_sys_i);
		num_errors++;
		give_verdict;
	end
endmodule
